// *** hw/hmp_device.sv ***
// Device end: host memory port into on-chip PM and DM
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "hmp_cfg.svh"
module hmp_device #(
   parameter int PM_WORDS = 64,
   parameter int DM_WORDS = 64
) (
   input wire logic pclk,
   input wire logic presetn,
   hmp_if.device port,
   input wire logic [2:0] boot_mode,
   input wire logic cpu_ctrl_we,
   input wire logic [13:0] cpu_ctrl_addr,
   input wire logic [15:0] cpu_ctrl_wdata,
   output logic exec_enable,
   output logic [15:0] ctrl_readback
);
   import hmp_pkg::*;
   initial begin
      if (PM_WORDS < 2 || PM_WORDS > 16384 || DM_WORDS < 2 || DM_WORDS > 16384)
         $error("memory size out of range");
   end
   typedef struct packed {
      logic [1:0][3:0] sync;
      hmp_dev_state_t state;
      logic is_write;
      logic pm_sel;
      logic [13:0] addr;
      logic [7:0] overlay;
      logic pm_half;
      logic [15:0] pm_high;
      logic al_prev;
      logic [15:0] lbus;
      logic [15:0] rdata;
      logic drive;
      logic boot_hold;
      logic boot_seen;
      logic [PM_WORDS-1:0][23:0] pm;
      logic [DM_WORDS-1:0][15:0] dm;
      logic [15:0] bus_s1;
      logic [15:0] bus_s2;
   } hmp_dev_st_t;
   hmp_dev_st_t st_reg, st_next;
   logic al_fall, s_sel, s_al, s_rd, s_wr, s_al_old;
   assign s_sel = st_reg.sync[1][0];
   assign s_al = st_reg.sync[1][1];
   assign s_rd = st_reg.sync[1][2];
   assign s_wr = st_reg.sync[1][3];
   assign s_al_old = st_reg.al_prev;
   // Only the second sync stage feeds the edge detector
   assign al_fall = s_al_old && !s_al;
   assign port.bus_dev_out = st_reg.rdata;
   assign port.bus_dev_oe = st_reg.drive;
   assign exec_enable = !st_reg.boot_hold;
   assign ctrl_readback = {1'b0, st_reg.pm_sel, st_reg.addr};
   assign port.host_access_ack_n = st_reg.state != HMP_IDLE;
   always_comb begin
      st_next = st_reg;
      st_next.sync[0] = {!port.host_write_strobe_n, !port.host_read_strobe_n,
                         port.host_address_latch, !port.host_port_select_n};
      st_next.sync[1] = st_reg.sync[0];
      st_next.bus_s1 = port.host_addr_data_bus;
      st_next.bus_s2 = st_reg.bus_s1;
      st_next.al_prev = s_al;
      // Keep the latch word while the strobe stands; the bus may move once it drops
      if (s_al) st_next.lbus = st_reg.bus_s2;
      if (!(s_sel && s_rd)) st_next.drive = 1'b0;
      case (st_reg.state)
         HMP_IDLE: begin
            // Busy from latch strobe to capture
            if (s_sel && s_al) begin
               st_next.state = HMP_DONE;
            end else if (s_sel && (s_rd || s_wr)) begin
               st_next.is_write = s_wr;
               st_next.state = HMP_SYNC;
            end
         end
         HMP_SYNC: st_next.state = HMP_ACCESS;
         HMP_ACCESS: begin
            if (st_reg.pm_sel) begin
               if (st_reg.is_write && st_reg.pm_half) begin
                  st_next.pm[st_reg.addr % PM_WORDS] = {st_reg.pm_high, st_reg.bus_s2[7:0]};
                  if (st_reg.addr == 14'h0000) st_next.boot_hold = 1'b0;
               end else if (st_reg.is_write) begin
                  st_next.pm_high = st_reg.bus_s2;
               end
               st_next.rdata = st_reg.pm_half ? {8'h00, st_reg.pm[st_reg.addr % PM_WORDS][7:0]}
                                              : st_reg.pm[st_reg.addr % PM_WORDS][23:8];
               st_next.pm_half = !st_reg.pm_half;
               if (st_reg.pm_half) st_next.addr = st_reg.addr + 14'h0001;
            end else begin
               // Control word not writable from host
               if (st_reg.is_write && st_reg.addr != `HMP_CTRL_DM_ADDR)
                  st_next.dm[st_reg.addr % DM_WORDS] = st_reg.bus_s2;
               st_next.rdata = st_reg.dm[st_reg.addr % DM_WORDS];
               st_next.addr = st_reg.addr + 14'h0001;
            end
            st_next.drive = !st_reg.is_write;
            st_next.state = HMP_DONE;
         end
         HMP_DONE: begin
            if (al_fall) begin
               if (st_reg.lbus[`HMP_OVL_FLAG_BIT]) begin
                  st_next.overlay = st_reg.lbus[7:0];
               end else begin
                  st_next.addr = st_reg.lbus[13:0];
                  st_next.pm_sel = !st_reg.lbus[`HMP_TYPE_BIT];
                  st_next.pm_half = 1'b0;
               end
            end
            if (!(s_rd || s_wr || s_al)) st_next.state = HMP_IDLE;
         end
         default: st_next.state = HMP_IDLE;
      endcase
      if (cpu_ctrl_we && cpu_ctrl_addr == `HMP_CTRL_DM_ADDR) begin
         st_next.addr = cpu_ctrl_wdata[13:0];
         st_next.pm_sel = !cpu_ctrl_wdata[`HMP_TYPE_BIT];
         st_next.pm_half = 1'b0;
      end
      if (!st_reg.boot_seen) begin
         st_next.boot_seen = 1'b1;
         st_next.boot_hold = boot_mode == `HMP_BOOT_MODE;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : hmp_device

// *** hw/hmp_cfg.svh ***
// Constants for the host memory port
//----------------------------------------------------------------
// Function
// - Host reaches PM and DM, one stolen cycle
// - Host writes never reach control registers
// - Host checks acknowledge before each access
// - Bit15 high latches overlay, bits 14:8 zero
// - Bit15 low latches address and memory type
// - One 16-bit shared bus, 24-bit PM words
// - Strobes asynchronous, accepted at full speed
// - Address increments after every DM access, after every second PM access
// - Address captured on latch strobe falling edge
// - Select plus latch writes control register
// - One sync cycle, then one memory cycle
// - Processor writes control register at 0x3FE0
// - Latched address never readable by host
// - Host waits acknowledge before next operation
// - Mode C1 B0 A1 selects host boot
// - Boot holds execution until PM 0 written
//----------------------------------------------------------------
`ifndef HMP_CFG_SVH
`define HMP_CFG_SVH
`define HMP_CTRL_DM_ADDR 14'h3fe0
`define HMP_OVL_FLAG_BIT 15
`define HMP_TYPE_BIT 14
`define HMP_BOOT_MODE 3'h5
`define HMP_APB_CMD 12'h000
`define HMP_APB_DATA 12'h004
`define HMP_APB_STAT 12'h008
`define HMP_APB_RDATA 12'h00c
`define HMP_APB_CPUCTL 12'h010
`define HMP_APB_CPUDAT 12'h014
`define HMP_CMD_LATCH 2'h1
`define HMP_CMD_WRITE 2'h2
`define HMP_CMD_READ 2'h3
`define HMP_STROBE_LAST 3'h7
`endif

// *** hw/hmp_pkg.sv ***
// Types for the host memory port
package hmp_pkg;
   typedef enum logic [2:0] {HMP_IDLE, HMP_SYNC, HMP_ACCESS, HMP_DONE} hmp_dev_state_t;
   typedef enum logic [2:0] {HMP_H_IDLE, HMP_H_WAIT, HMP_H_STROBE, HMP_H_END}
      hmp_host_state_t;
endpackage : hmp_pkg

// *** hw/hmp_if.sv ***
// Interface joining host and device ends of the port
`timescale 1ns/10ps
interface hmp_if;
   logic host_port_select_n;
   logic host_address_latch;
   logic host_read_strobe_n;
   logic host_write_strobe_n;
   logic [15:0] bus_host_out;
   logic bus_host_oe;
   logic [15:0] bus_dev_out;
   logic bus_dev_oe;
   logic host_access_ack_n;
   logic [15:0] host_addr_data_bus;
   assign host_addr_data_bus = bus_host_oe ? bus_host_out :
                               (bus_dev_oe ? bus_dev_out : 16'hffff);
   modport device (input host_port_select_n, input host_address_latch,
                   input host_read_strobe_n, input host_write_strobe_n,
                   input host_addr_data_bus, output bus_dev_out, output bus_dev_oe,
                   output host_access_ack_n);
   modport host (output host_port_select_n, output host_address_latch,
                 output host_read_strobe_n, output host_write_strobe_n,
                 input host_addr_data_bus, output bus_host_out, output bus_host_oe,
                 input host_access_ack_n);
endinterface : hmp_if

// *** hw/hmp_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module hmp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } hmp_fifo_st_t;
   hmp_fifo_st_t st_reg, st_next;
   logic full, empty;
   assign empty = st_reg.wp == st_reg.rp;
   assign full = (st_reg.wp[AW] != st_reg.rp[AW]) && (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = st_reg.mem[st_reg.rp[AW-1:0]];
   always_comb begin
      st_next = st_reg;
      if (in_valid && !full) begin
         st_next.mem[st_reg.wp[AW-1:0]] = in_data;
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (out_ready && !empty) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : hmp_fifo

// *** hw/hmp_host.sv ***
// Host end: APB-controlled driver for the host memory port
`timescale 1ns/10ps
`include "hmp_cfg.svh"
module hmp_host (
   input wire logic pclk,
   input wire logic presetn,
   hmp_if.host port,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import hmp_pkg::*;
   typedef struct packed {
      hmp_host_state_t state;
      logic [1:0] cmd;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic [1:0] ack_s;
      logic [15:0] bus_s1;
      logic [15:0] bus_s2;
      logic [2:0] hold;
      logic sel;
      logic al;
      logic rd;
      logic wr;
      logic oe;
      logic rvalid;
   } hmp_host_st_t;
   hmp_host_st_t st_reg, st_next;
   logic fifo_in_ready, fifo_out_valid;
   logic [17:0] fifo_out_data;
   logic cmd_wr, fifo_pop;
   assign cmd_wr = psel && penable && pwrite && paddr == `HMP_APB_CMD;
   assign pready = !(cmd_wr && !fifo_in_ready);
   assign pslverr = 1'b0;
   assign port.host_port_select_n = !st_reg.sel;
   assign port.host_address_latch = st_reg.al;
   assign port.host_read_strobe_n = !st_reg.rd;
   assign port.host_write_strobe_n = !st_reg.wr;
   assign port.bus_host_out = st_reg.wdata;
   assign port.bus_host_oe = st_reg.oe;
   assign fifo_pop = st_reg.state == HMP_H_IDLE && fifo_out_valid;
   hmp_fifo #(.WIDTH(18), .DEPTH(8)) u_fifo (
      .pclk(pclk), .presetn(presetn),
      .in_valid(cmd_wr), .in_ready(fifo_in_ready), .in_data({pwdata[17:16], pwdata[15:0]}),
      .out_valid(fifo_out_valid), .out_ready(fifo_pop), .out_data(fifo_out_data)
   );
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         `HMP_APB_STAT: prdata = {29'h0, st_reg.rvalid, fifo_out_valid,
                                  (st_reg.state != HMP_H_IDLE) || !st_reg.ack_s[1]};
         `HMP_APB_RDATA: prdata = {16'h0000, st_reg.rdata};
         default: prdata = 32'h0000_0000;
      endcase
   end
   always_comb begin
      st_next = st_reg;
      st_next.ack_s = {st_reg.ack_s[0], !port.host_access_ack_n};
      st_next.bus_s1 = port.host_addr_data_bus;
      st_next.bus_s2 = st_reg.bus_s1;
      if (psel && penable && !pwrite && paddr == `HMP_APB_RDATA) st_next.rvalid = 1'b0;
      case (st_reg.state)
         HMP_H_IDLE: begin
            if (fifo_out_valid) begin
               st_next.cmd = fifo_out_data[17:16];
               st_next.wdata = fifo_out_data[15:0];
               st_next.state = HMP_H_WAIT;
            end
         end
         HMP_H_WAIT: begin
            if (st_reg.ack_s[1]) begin
               st_next.sel = 1'b1;
               st_next.al = st_reg.cmd == `HMP_CMD_LATCH;
               st_next.wr = st_reg.cmd == `HMP_CMD_WRITE;
               st_next.rd = st_reg.cmd == `HMP_CMD_READ;
               st_next.oe = st_reg.cmd != `HMP_CMD_READ;
               if (st_reg.wdata[`HMP_OVL_FLAG_BIT] && st_reg.cmd == `HMP_CMD_LATCH)
                  st_next.wdata[14:8] = 7'h00;
               st_next.hold = 3'h0;
               st_next.state = HMP_H_STROBE;
            end
         end
         HMP_H_STROBE: begin
            st_next.hold = st_reg.hold + 3'h1;
            // Strobe held long enough to cover sync and access
            if (st_reg.hold == `HMP_STROBE_LAST) begin
               if (st_reg.rd) begin
                  st_next.rdata = st_reg.bus_s2;
                  st_next.rvalid = 1'b1;
               end
               st_next.sel = 1'b0;
               st_next.al = 1'b0;
               st_next.rd = 1'b0;
               st_next.wr = 1'b0;
               st_next.state = HMP_H_END;
            end
         end
         HMP_H_END: begin
            st_next.oe = 1'b0;
            st_next.state = HMP_H_IDLE;
         end
         default: st_next.state = HMP_H_IDLE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : hmp_host

// *** testbench/hmp_port_chk.sv ***
// Wire-level checks on the host memory port
`timescale 1ns/10ps
module hmp_port_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic host_port_select_n,
   input wire logic host_address_latch,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic bus_host_oe,
   input wire logic bus_dev_oe,
   input wire logic host_access_ack_n,
   input wire logic [15:0] host_addr_data_bus
);
   logic stb;
   // Either data strobe active
   assign stb = !host_read_strobe_n || !host_write_strobe_n;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_strobe_select: assert property (stb || host_address_latch |-> !host_port_select_n)
      else $error("strobe without select");
   a_one_strobe: assert property (!(!host_read_strobe_n && !host_write_strobe_n))
      else $error("read and write strobes together");
   a_ack_first: assert property ($rose(stb) |-> !host_access_ack_n)
      else $error("strobe while port busy");
   a_sync_delay: assert property ($rose(stb) |=> !host_access_ack_n)
      else $error("busy before sync cycle");
   a_ack_busy: assert property ($rose(stb) |-> ##[2:7] host_access_ack_n)
      else $error("busy never shown");
   a_strobe_hold: assert property ($rose(stb) |-> stb [*8])
      else $error("strobe too short");
   a_ack_return: assert property ($fell(stb) |-> ##[1:6] !host_access_ack_n)
      else $error("ready not restored");
   a_ovl_zero: assert property (host_address_latch && host_addr_data_bus[15]
      |-> host_addr_data_bus[14:8] == 7'h00) else $error("overlay high bits set");
   a_no_readback: assert property (host_address_latch || !host_write_strobe_n
      |-> !bus_dev_oe) else $error("device drives bus outside read");
   a_no_clash: assert property (!(bus_host_oe && bus_dev_oe))
      else $error("both ends drive bus");
endmodule : hmp_port_chk

// *** testbench/host_internal_memory_port_tb.sv ***
// Testbench joining host and device ends over APB
`timescale 1ns/10ps
`include "hmp_cfg.svh"
module host_internal_memory_port_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic pready, pslverr, exec_enable, cpu_ctrl_we = 0;
   logic [2:0] boot_mode = `HMP_BOOT_MODE;
   logic [13:0] cpu_ctrl_addr = 14'h0000, a;
   logic [15:0] cpu_ctrl_wdata = 16'h0000, ctrl_readback, v, dm [12];
   logic [23:0] w;
   int num_errors = 0, checked = 0, stalls = 0, seed = 10326;
   hmp_if u_hmp_if ();
   hmp_host u_hmp_host (.pclk(pclk), .presetn(presetn), .port(u_hmp_if.host), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   hmp_device u_hmp_device (.pclk(pclk), .presetn(presetn), .port(u_hmp_if.device),
      .boot_mode(boot_mode), .cpu_ctrl_we(cpu_ctrl_we), .cpu_ctrl_addr(cpu_ctrl_addr),
      .cpu_ctrl_wdata(cpu_ctrl_wdata), .exec_enable(exec_enable),
      .ctrl_readback(ctrl_readback));
   hmp_port_chk u_chk (.pclk(pclk), .presetn(presetn),
      .host_port_select_n(u_hmp_if.host_port_select_n),
      .host_address_latch(u_hmp_if.host_address_latch),
      .host_read_strobe_n(u_hmp_if.host_read_strobe_n),
      .host_write_strobe_n(u_hmp_if.host_write_strobe_n),
      .bus_host_oe(u_hmp_if.bus_host_oe), .bus_dev_oe(u_hmp_if.bus_dev_oe),
      .host_access_ack_n(u_hmp_if.host_access_ack_n),
      .host_addr_data_bus(u_hmp_if.host_addr_data_bus));
   initial begin
      forever #10 pclk = ~pclk;
   end
   // Queue-full stalls show the FIFO refusing
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b0) stalls++;
   end
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (e !== g) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      check("pslverr", 0, pslverr);
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic cmd(input logic [1:0] c, input logic [15:0] d);
      apb(1, `HMP_APB_CMD, {14'h0000, c, d});
   endtask : cmd
   // Wait until queue drained and link idle
   task automatic idle();
      for (int i = 0; i < 400; i++) begin
         apb(0, `HMP_APB_STAT, 0);
         if (r[1:0] === 2'h0) break;
      end
   endtask : idle
   task automatic rd16(output logic [15:0] q);
      cmd(`HMP_CMD_READ, 16'h0000);
      for (int i = 0; i < 400; i++) begin
         apb(0, `HMP_APB_STAT, 0);
         if (r[2] === 1'b1) break;
      end
      apb(0, `HMP_APB_RDATA, 0);
      q = r[15:0];
   endtask : rd16
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      close_out();
   end
   initial begin
      w = $random(seed);
      repeat (3) @(posedge pclk);
      presetn <= 1;
      repeat (2) @(negedge pclk);
      check("boot hold", 0, exec_enable);
      cmd(`HMP_CMD_LATCH, 16'h0000);
      idle();
      check("hold after latch", 0, exec_enable);
      check("latched pm", 16'h4000, ctrl_readback);
      cmd(`HMP_CMD_WRITE, w[23:8]);
      cmd(`HMP_CMD_WRITE, {8'h00, w[7:0]});
      idle();
      check("boot run", 1, exec_enable);
      check("pm incr", 1, ctrl_readback[13:0]);
      // Back-to-back DM writes overrun the link and fill the queue
      a = $unsigned($random(seed)) % 4;
      cmd(`HMP_CMD_LATCH, 16'h4000 | a);
      for (int i = 0; i < 12; i++) begin
         dm[i] = $random(seed);
         cmd(`HMP_CMD_WRITE, dm[i]);
      end
      idle();
      check("queue stall", 1, stalls > 0);
      check("dm incr", a + 12, ctrl_readback);
      cmd(`HMP_CMD_LATCH, 16'h4000 | a);
      for (int i = 0; i < 12; i++) begin
         rd16(v);
         check("dm data", dm[i], v);
      end
      cmd(`HMP_CMD_LATCH, 16'h0000);
      rd16(v);
      rd16(r[15:0]);
      check("pm word", w, {v, r[7:0]});
      idle();
      cmd(`HMP_CMD_LATCH, 16'h8000 | ($random(seed) & 16'h00ff));
      idle();
      check("overlay keeps addr", 16'h4001, ctrl_readback);
      @(posedge pclk);
      cpu_ctrl_we <= 1;
      cpu_ctrl_addr <= `HMP_CTRL_DM_ADDR;
      cpu_ctrl_wdata <= 16'h4005;
      @(posedge pclk);
      cpu_ctrl_we <= 0;
      @(posedge pclk);
      check("cpu ctrl", 5, ctrl_readback[13:0]);
      rd16(v);
      check("cpu addr data", dm[5 - a], v);
      cmd(`HMP_CMD_LATCH, 16'h4000 | `HMP_CTRL_DM_ADDR);
      cmd(`HMP_CMD_WRITE, 16'h4003);
      idle();
      check("ctrl protected", 14'h3fe1, ctrl_readback[13:0]);
      cmd(`HMP_CMD_LATCH, 16'h4000 | `HMP_CTRL_DM_ADDR);
      rd16(v);
      check("ctrl not stored", 0, v);
      apb(0, 12'h020, 0);
      check("unmapped", 0, r);
      close_out();
   end
endmodule : host_internal_memory_port_tb
